// *** design/ata_cmd_core.sv ***
// Purpose: Command sequencer for power query, trim, erase, diagnostic, flush
// Assumes: Task-file writes come from logic on the same clock
// Notes: Media work is delegated through a start/done handshake
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_map.svh"
module ata_cmd_core (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdOpcode,
  input wire logic [7:0] features,
  input wire logic [7:0] sectorCount,
  input wire logic [7:0] sectorNumber,
  input wire logic [7:0] cylinderLow,
  input wire logic [7:0] cylinderHigh,
  input wire logic [7:0] driveHead,
  input wire logic ideMode,
  input wire logic thisDrive,
  input wire logic isMaster,
  input wire logic inStandby,
  input wire logic flushSupported,
  input wire logic workDone,
  input wire logic workFault,
  input wire logic [7:0] selfTestCode,
  input wire logic slaveDiagFail,
  input wire logic [3:0] slaveDiagCode,
  output ata_cmd_pkg::cmd_kind_type workKind,
  output logic workStart,
  output logic [27:0] workLba,
  output logic [7:0] workCount,
  output logic [7:0] statusOut,
  output logic [7:0] errorOut,
  output logic [7:0] countOut,
  output logic countLoad,
  output logic interrupt
);
  import ata_cmd_pkg::*;
  seq_state_type state_q, state_d;
  cmd_kind_type kind_q, decKind;
  logic [7:0] status_q, error_q, count_q;
  logic countLoad_q, irq_q, start_q;
  logic [27:0] lba_q;
  logic [7:0] wcount_q;

  ata_opcode_decode u_decode (
    .opcode(cmdOpcode),
    .features(features),
    .sectorCount(sectorCount),
    .flushSupported(flushSupported),
    .kind(decKind)
  );

  // ************************************
  // Selection
  // ************************************
  wire driveSel = driveHead[`DRIVE_BIT] == thisDrive;
  wire acceptCmd = cmdWrite && (state_q == ST_IDLE) && (ideMode || driveSel);
  wire needsWork = (kind_q == CMD_TRIM) || (kind_q == CMD_ERASE) ||
                   (kind_q == CMD_FLUSH) || (kind_q == CMD_DIAG);
  wire [27:0] startLba = {driveHead[3:0], cylinderHigh, cylinderLow, sectorNumber};
  wire [7:0] powerCount = inStandby ? `COUNT_STANDBY : `COUNT_IDLE;
  wire diagSlaveBad = ideMode && isMaster && slaveDiagFail;
  wire [7:0] diagCode = diagSlaveBad ? {`DIAG_SLAVE_FAIL_HI, slaveDiagCode} : selfTestCode;
  wire faultNow = workFault && (kind_q != CMD_DIAG);

  // ************************************
  // Sequencer
  // ************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (acceptCmd) state_d = ST_BUSY;
      ST_BUSY: state_d = needsWork ? ST_WORK : ST_DONE;
      ST_WORK: if (workDone) state_d = ST_DONE;
      ST_DONE: state_d = ST_IRQ;
      ST_IRQ: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      kind_q <= CMD_NONE;
      lba_q <= 28'h000_0000;
      wcount_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (acceptCmd) begin
        kind_q <= decKind;
        lba_q <= startLba;
        wcount_q <= sectorCount;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_q <= `STS_AT_RESET;
      error_q <= `ERR_FREE;
      count_q <= 8'h00;
      countLoad_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      countLoad_q <= 1'b0;
      start_q <= (state_q == ST_BUSY) && needsWork;
      if (acceptCmd) begin
        status_q <= `STS_CMD_BUSY;
        error_q <= `ERR_FREE;
      end else if (state_q == ST_BUSY && kind_q == CMD_POWER) begin
        count_q <= powerCount;
        countLoad_q <= 1'b1;
      end else if (state_q == ST_BUSY && kind_q == CMD_ABORT) begin
        error_q <= `ERR_ABORTED;
      end else if (state_q == ST_WORK && workDone) begin
        if (kind_q == CMD_DIAG) error_q <= diagCode;
        if (faultNow) status_q[`STS_DWF_BIT] <= 1'b1;
      end else if (state_q == ST_DONE) begin
        status_q[`STS_BSY_BIT] <= 1'b0;
        status_q[`STS_RDY_BIT] <= 1'b1;
        status_q[`STS_DSC_BIT] <= 1'b1;
        status_q[`STS_ERR_BIT] <= (kind_q == CMD_ABORT) || status_q[`STS_DWF_BIT];
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) irq_q <= 1'b0;
    else irq_q <= (state_q == ST_IRQ) ? 1'b1 : (acceptCmd ? 1'b0 : irq_q);
  end

  assign statusOut = status_q;
  assign errorOut = error_q;
  assign countOut = count_q;
  assign countLoad = countLoad_q;
  assign interrupt = irq_q;
  assign workStart = start_q;
  assign workKind = kind_q;
  assign workLba = lba_q;
  assign workCount = wcount_q;

  // ************************************
  // Checks
  // ************************************
  property p_busy_on_cmd;
    @(posedge clock) disable iff (reset) acceptCmd |=> statusOut[`STS_BSY_BIT];
  endproperty
  a_busy_on_cmd: assert property (p_busy_on_cmd) else $error("busy not set");
  property p_irq_after_busy;
    @(posedge clock) disable iff (reset) $rose(interrupt) |-> !statusOut[`STS_BSY_BIT];
  endproperty
  a_irq_after_busy: assert property (p_irq_after_busy) else $error("irq with busy");
  property p_power_count;
    @(posedge clock) disable iff (reset)
      (state_q == ST_BUSY && kind_q == CMD_POWER) |=> countLoad && countOut == $past(powerCount);
  endproperty
  a_power_count: assert property (p_power_count) else $error("bad power count");
  property p_power_irq;
    @(posedge clock) disable iff (reset) (countLoad && kind_q == CMD_POWER) |-> ##2 interrupt;
  endproperty
  a_power_irq: assert property (p_power_irq) else $error("no power irq");
  property p_abort;
    @(posedge clock) disable iff (reset)
      (state_q == ST_DONE && kind_q == CMD_ABORT) |=>
        errorOut[`ERR_ABORT_BIT] && statusOut[`STS_ERR_BIT];
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_flush_done;
    @(posedge clock) disable iff (reset)
      (state_q == ST_WORK && kind_q == CMD_FLUSH) |-> statusOut[`STS_BSY_BIT];
  endproperty
  a_flush_done: assert property (p_flush_done) else $error("flush early");
  property p_diag_code;
    @(posedge clock) disable iff (reset)
      (state_q == ST_WORK && workDone && kind_q == CMD_DIAG) |=> errorOut == $past(diagCode);
  endproperty
  a_diag_code: assert property (p_diag_code) else $error("bad diag code");
  property p_select;
    @(posedge clock) disable iff (reset)
      (cmdWrite && state_q == ST_IDLE && !ideMode && !driveSel) |=> state_q == ST_IDLE;
  endproperty
  a_select: assert property (p_select) else $error("wrong drive ran");
  property p_lba;
    @(posedge clock) disable iff (reset) acceptCmd |=> workLba == $past(startLba);
  endproperty
  a_lba: assert property (p_lba) else $error("bad lba");
  property p_busy_hold;
    @(posedge clock) disable iff (reset)
      (state_q == ST_BUSY || state_q == ST_WORK || state_q == ST_DONE) |->
        statusOut[`STS_BSY_BIT];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_fault_err;
    @(posedge clock) disable iff (reset)
      (state_q == ST_IRQ && statusOut[`STS_DWF_BIT]) |-> statusOut[`STS_ERR_BIT];
  endproperty
  a_fault_err: assert property (p_fault_err) else $error("fault without error");
  property p_ide_take;
    @(posedge clock) disable iff (reset)
      (cmdWrite && state_q == ST_IDLE && ideMode) |=> state_q == ST_BUSY;
  endproperty
  a_ide_take: assert property (p_ide_take) else $error("ide command dropped");
  property p_flush_ready;
    @(posedge clock) disable iff (reset)
      (state_q == ST_IRQ && kind_q == CMD_FLUSH) |->
        statusOut[`STS_RDY_BIT] && statusOut[`STS_DSC_BIT];
  endproperty
  a_flush_ready: assert property (p_flush_ready) else $error("flush not ready");
  property p_slave_code;
    @(posedge clock) disable iff (reset)
      (state_q == ST_WORK && workDone && kind_q == CMD_DIAG && diagSlaveBad) |=>
        errorOut[7:4] == `DIAG_SLAVE_FAIL_HI;
  endproperty
  a_slave_code: assert property (p_slave_code) else $error("bad slave code");
  property p_trim_zero;
    @(posedge clock) disable iff (reset)
      (acceptCmd && cmdOpcode == `OP_DATA_SET_MGMT && sectorCount == '0) |=>
        workKind == CMD_ABORT;
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("zero trim taken");

  // ************************************
  // Covers
  // ************************************
  c_power: cover property (@(posedge clock) countLoad);
  c_flush: cover property (@(posedge clock) state_q == ST_WORK && kind_q == CMD_FLUSH);
  c_diag: cover property (@(posedge clock) diagSlaveBad && workDone);
  c_abort: cover property (@(posedge clock) state_q == ST_DONE && kind_q == CMD_ABORT);
  c_fault: cover property (@(posedge clock) faultNow && workDone);
endmodule : ata_cmd_core
`default_nettype wire

// *** design/ata_cmd_map.svh ***
// Purpose: Constants for the ATA command slice (opcodes, codes, field positions)
// Assumes: Included by the command interpreter files
// Notes: Field positions refer to task-file register bytes
// How it works
// - Decode E5h and 98h as power query
// - Standby: busy, count 00h, unbusy, interrupt
// - Idle: busy, count FFh, unbusy, interrupt
// - Opcode 06h is data set management
// - Trim only via features bit 0; count zero reserved
// - Opcode C0h erases sectors; write fault possible
// - Erase start address from head, cylinders, sector
// - Opcode 90h runs internal diagnostic
// - Card mode: diagnostic only on selected drive
// - IDE mode: both run, master reports both
// - Diagnostic code 01h..05h in error register
// - Slave failure reported as 8Xh by master
// - Flush E7h completes ready+seek-done after media
// - Unsupported flush aborts
`ifndef ATA_CMD_MAP_SVH
`define ATA_CMD_MAP_SVH
`define OP_POWER_QUERY 8'hE5
`define OP_POWER_QUERY_OLD 8'h98
`define OP_DATA_SET_MGMT 8'h06
`define OP_ERASE_SECTORS 8'hC0
`define OP_DIAGNOSTIC 8'h90
`define OP_FLUSH_CACHE 8'hE7
`define COUNT_STANDBY 8'h00
`define COUNT_IDLE 8'hFF
`define DIAG_NO_ERROR 8'h01
`define DIAG_SLAVE_FAIL_HI 4'h8
`define ERR_ABORT_BIT 2
`define ERR_FREE 8'h00
`define ERR_ABORTED 8'h04
`define STS_AT_RESET 8'h50
`define STS_CMD_BUSY 8'h80
`define STS_ERR_BIT 0
`define STS_DSC_BIT 4
`define STS_DWF_BIT 5
`define STS_RDY_BIT 6
`define STS_BSY_BIT 7
`define DRIVE_BIT 4
`define TRIM_BIT 0
`define DIAG_WAIT 8'h0F
`endif

// *** design/ata_cmd_pkg.sv ***
// Purpose: Types for the ATA command slice
// Assumes: Nothing
// Notes: States of the command sequencer
package ata_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BUSY = 3'b001,
    ST_WORK = 3'b010,
    ST_DONE = 3'b011,
    ST_IRQ = 3'b100
  } seq_state_type;
  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_POWER = 3'b001,
    CMD_TRIM = 3'b010,
    CMD_ERASE = 3'b011,
    CMD_DIAG = 3'b100,
    CMD_FLUSH = 3'b101,
    CMD_ABORT = 3'b110
  } cmd_kind_type;
endpackage : ata_cmd_pkg

// *** design/ata_opcode_decode.sv ***
// Purpose: Classifies a command opcode into a command kind
// Assumes: Opcode is stable while decode is read
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_map.svh"
module ata_opcode_decode (
  input wire logic [7:0] opcode,
  input wire logic [7:0] features,
  input wire logic [7:0] sectorCount,
  input wire logic flushSupported,
  output ata_cmd_pkg::cmd_kind_type kind
);
  import ata_cmd_pkg::*;
  wire isPower = (opcode == `OP_POWER_QUERY) || (opcode == `OP_POWER_QUERY_OLD);
  wire trimOk = features[`TRIM_BIT] && (sectorCount != 8'h00);
  wire isTrim = (opcode == `OP_DATA_SET_MGMT) && trimOk;
  wire isErase = opcode == `OP_ERASE_SECTORS;
  wire isDiag = opcode == `OP_DIAGNOSTIC;
  wire isFlush = (opcode == `OP_FLUSH_CACHE) && flushSupported;
  assign kind = isPower ? CMD_POWER :
                isTrim ? CMD_TRIM :
                isErase ? CMD_ERASE :
                isDiag ? CMD_DIAG :
                isFlush ? CMD_FLUSH : CMD_ABORT;
endmodule : ata_opcode_decode
`default_nettype wire

// *** tb/media_model.sv ***
// Purpose: Media and self-test engine answering work requests
// Assumes: One request at a time, started by workStart
// Notes: slow gives a long answer; fault is shown only with workDone
`timescale 1ns/1ps
`default_nettype none
module media_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic workStart,
  input wire logic slow,
  input wire logic fault,
  output logic workDone,
  output logic workFault
);
  logic [4:0] left_q;
  logic done_q;
  logic toggle_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      left_q <= 5'h00;
      done_q <= 1'b0;
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
      done_q <= (left_q == 5'h01);
      if (workStart) begin
        left_q <= slow ? 5'h14 : 5'h02;
      end else if (left_q != 5'h00) begin
        left_q <= left_q - 5'h01;
      end
    end
  end
  assign workDone = done_q;
  // Fault flag is meaningless outside the done pulse, so it wanders
  assign workFault = done_q ? fault : toggle_q;
endmodule : media_model
`default_nettype wire

// *** tb/storage_card_command_set_part_tb_top.sv ***
// Purpose: Self-checking bench of the command sequencer
// Assumes: media_model answers work requests
// Notes: Each scenario issues commands and checks the completion state
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module storage_card_command_set_part_tb_top;
  import ata_cmd_pkg::*;
  logic clock, reset, cmdWrite, ideMode, thisDrive, isMaster, inStandby;
  logic flushSupported, slaveDiagFail, slow, fault, workDone, workFault;
  logic [7:0] cmdOpcode, features, sectorCount, sectorNumber, cylinderLow;
  logic [7:0] cylinderHigh, driveHead, selfTestCode, statusOut, errorOut, countOut;
  logic [7:0] workCount;
  logic [3:0] slaveDiagCode;
  logic [27:0] workLba;
  logic workStart, countLoad, interrupt;
  cmd_kind_type workKind;
  int fails = 0;
  int cmpCount = 0;
  ata_cmd_core ata_cmd_core_i (.clock(clock), .reset(reset), .cmdWrite(cmdWrite),
    .cmdOpcode(cmdOpcode), .features(features), .sectorCount(sectorCount),
    .sectorNumber(sectorNumber), .cylinderLow(cylinderLow), .cylinderHigh(cylinderHigh),
    .driveHead(driveHead), .ideMode(ideMode), .thisDrive(thisDrive), .isMaster(isMaster),
    .inStandby(inStandby), .flushSupported(flushSupported), .workDone(workDone),
    .workFault(workFault), .selfTestCode(selfTestCode), .slaveDiagFail(slaveDiagFail),
    .slaveDiagCode(slaveDiagCode), .workKind(workKind), .workStart(workStart),
    .workLba(workLba), .workCount(workCount), .statusOut(statusOut), .errorOut(errorOut),
    .countOut(countOut), .countLoad(countLoad), .interrupt(interrupt));
  media_model media_model_i (.clock(clock), .reset(reset), .workStart(workStart),
    .slow(slow), .fault(fault), .workDone(workDone), .workFault(workFault));
  always #2.5 clock = ~clock;
  task automatic closeOut();
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : closeOut
  task automatic issue(input logic [7:0] op, ft, sc, dh);
    @(posedge clock);
    cmdOpcode <= op;
    features <= ft;
    sectorCount <= sc;
    driveHead <= dh;
    cmdWrite <= 1'b1;
    @(posedge clock);
    cmdWrite <= 1'b0;
    @(posedge clock);
    #1;
  endtask : issue
  task automatic waitIrq();
    int n;
    n = 0;
    `CHK({statusOut[7], interrupt}, 2'b10)
    while (interrupt !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 200) begin
      fails++;
      closeOut();
    end
    `CHK(statusOut[7], 1'b0)
  endtask : waitIrq
  task automatic run(input logic [7:0] op, ft, sc, dh, input logic abt);
    issue(op, ft, sc, dh);
    waitIrq();
    `CHK(statusOut[0], abt)
    if (abt) `CHK(errorOut, 8'h04)
  endtask : run
  task automatic powerScn();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      inStandby <= i[0];
      issue(i[1] ? 8'h98 : 8'hE5, 8'h00, 8'h00, 8'h00);
      `CHK(countLoad, 1'b1)
      waitIrq();
      `CHK(statusOut[0], 1'b0)
      `CHK(countOut, i[0] ? 8'h00 : 8'hFF)
    end
  endtask : powerScn
  task automatic trimScn();
    @(posedge clock);
    sectorCount <= 8'h00;
    issue(8'h06, 8'h01, 8'h01, 8'h00);
    `CHK(workStart, 1'b1)
    waitIrq();
    `CHK(statusOut[0], 1'b0)
    `CHK(workKind, CMD_TRIM)
    run(8'h06, 8'h00, 8'h01, 8'h00, 1'b1);
    run(8'h06, 8'h01, 8'h00, 8'h00, 1'b1);
  endtask : trimScn
  task automatic eraseScn();
    @(posedge clock);
    cylinderHigh <= 8'h12;
    cylinderLow <= 8'h34;
    sectorNumber <= 8'h56;
    slow <= 1'b1;
    run(8'hC0, 8'h00, 8'h07, 8'h0A, 1'b0);
    `CHK({workKind, workLba, workCount}, {CMD_ERASE, 28'hA12_3456, 8'h07})
    fault <= 1'b1;
    issue(8'hC0, 8'h00, 8'h01, 8'h0A);
    waitIrq();
    `CHK(statusOut[0], 1'b1)
    `CHK(errorOut, 8'h00)
    `CHK(statusOut[5], 1'b1)
    fault <= 1'b0;
    slow <= 1'b0;
  endtask : eraseScn
  task automatic diagScn();
    @(posedge clock);
    selfTestCode <= 8'h03;
    issue(8'h90, 8'h00, 8'h00, 8'h10);
    `CHK({statusOut[7], interrupt}, 2'b01)
    run(8'h90, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(errorOut, 8'h03)
    ideMode <= 1'b1;
    for (int c = 1; c < 6; c++) begin
      @(posedge clock);
      selfTestCode <= 8'(c);
      run(8'h90, 8'h00, 8'h00, 8'h10, 1'b0);
      `CHK(errorOut, 8'(c))
    end
    slaveDiagFail <= 1'b1;
    run(8'h90, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(errorOut, 8'h85)
    isMaster <= 1'b0;
    run(8'h90, 8'h00, 8'h00, 8'h00, 1'b0);
    `CHK(errorOut, 8'h05)
    isMaster <= 1'b1;
  endtask : diagScn
  task automatic flushScn();
    @(posedge clock);
    slow <= 1'b1;
    issue(8'hE7, 8'h00, 8'h00, 8'h00);
    repeat (8) @(posedge clock);
    #1;
    waitIrq();
    `CHK({statusOut[6], statusOut[4], statusOut[0]}, 3'b110)
    flushSupported <= 1'b0;
    run(8'hE7, 8'h00, 8'h00, 8'h00, 1'b1);
    run(8'h50, 8'h00, 8'h00, 8'h00, 1'b1);
  endtask : flushScn
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {cmdWrite, ideMode, thisDrive, inStandby, slaveDiagFail, slow, fault} = '0;
    {isMaster, flushSupported} = 2'b11;
    {cmdOpcode, features, sectorCount, sectorNumber, cylinderLow} = '0;
    {cylinderHigh, driveHead, selfTestCode, slaveDiagCode} = {24'h00_0000, 8'h01, 4'h5};
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    powerScn();
    trimScn();
    eraseScn();
    diagScn();
    flushScn();
    closeOut();
  end
endmodule : storage_card_command_set_part_tb_top
`default_nettype wire
